// ===== hdl/hpsc_pkg.sv
package hpsc_pkg;

    // Register map
    localparam logic [11:0] HPSC_SLOT_ADDR = 12'h0D8;
    localparam int HPSC_ADDR_W = 12;

    // Control field positions
    localparam int HPSC_CTL_BTN_EN = 0;
    localparam int HPSC_CTL_PF_EN = 1;
    localparam int HPSC_CTL_LATCH_EN = 2;
    localparam int HPSC_CTL_PRES_EN = 3;
    localparam int HPSC_CTL_CMD_EN = 4;
    localparam int HPSC_CTL_HP_EN = 5;
    localparam int HPSC_CTL_ATT_LO = 6;
    localparam int HPSC_CTL_PWRIND_LO = 8;
    localparam int HPSC_CTL_PWR_OFF = 10;
    localparam int HPSC_CTL_INTERLOCK = 11;
    localparam int HPSC_CTL_DLL_EN = 12;

    // Status field positions
    localparam int HPSC_ST_BTN = 16;
    localparam int HPSC_ST_PF = 17;
    localparam int HPSC_ST_LATCH_CHG = 18;
    localparam int HPSC_ST_PRES_CHG = 19;
    localparam int HPSC_ST_CMD = 20;
    localparam int HPSC_ST_LATCH = 21;
    localparam int HPSC_ST_PRES = 22;
    localparam int HPSC_ST_DLL_CHG = 24;

    // Writable control bits 12:0, reserved 15:13 read zero
    localparam logic [15:0] HPSC_CTL_WMASK = 16'h1FFF;
    // Control reset: attention off (11), power indicator on (01)
    localparam logic [15:0] HPSC_CTL_RESET = 16'h01C0;
    localparam logic [31:0] HPSC_ZERO32 = 32'h0000_0000;

    // Indicator encodings
    localparam logic [1:0] HPSC_IND_RSVD = 2'h0;
    localparam logic [1:0] HPSC_IND_ON = 2'h1;
    localparam logic [1:0] HPSC_IND_BLINK = 2'h2;
    localparam logic [1:0] HPSC_IND_OFF = 2'h3;

    // Slot-side levels, all asynchronous to pclk
    typedef struct packed {
        logic button;         // Attention button pressed
        logic power_fault;    // Slot power fault
        logic retention_latch; // Latch sensor, 1 = opened
        logic presence;       // Card present
        logic link_active;    // Data link layer link active
        logic slot_impl;      // Port is wired to a slot
    } hpsc_pins_type;

    // Sense levels assumed while in reset: slot wired, everything else idle,
    // so the edge stage sees no false change when the first real samples arrive
    localparam hpsc_pins_type HPSC_PINS_IDLE = 6'h01;

    // Indicator message request
    typedef struct packed {
        logic valid;          // One-cycle send request
        logic [1:0] code;     // Indicator state to announce
    } hpsc_msg_type;

    // Bus answer state
    typedef enum logic [0:0] {
        HPSC_APB_WAIT = 1'b0,
        HPSC_APB_ANSWER = 1'b1
    } hpsc_apb_state_type;

endpackage

// ===== hdl/hpsc_slot_ctrl.sv
// Local design decision: the APB register port.
`timescale 1ns/1ps
module hpsc_slot_ctrl
    import hpsc_pkg::*;
(
    input wire logic pclk, // Bus clock, 10 MHz
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, 1 write
    input wire logic [HPSC_ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB write byte lanes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire hpsc_pins_type slot_pins, // Slot sense lines
    output logic hp_irq, // Hot-plug interrupt request
    output logic [1:0] att_ind, // Attention indicator state
    output logic [1:0] pwr_ind, // Power indicator state
    output logic slot_power_off, // Slot power, 1 off
    output hpsc_msg_type att_msg, // Attention indicator message
    output hpsc_msg_type pwr_msg // Power indicator message
);

    // Address decode shared by read and write paths
    function automatic logic slot_hit(input logic [HPSC_ADDR_W-1:0] addr);
        slot_hit = (addr == HPSC_SLOT_ADDR);
    endfunction

    hpsc_pins_type sync1_reg, sync2_reg, prev_reg;
    hpsc_apb_state_type state_reg, state_next;
    logic [15:0] ctl_reg, ctl_next;
    logic [8:0] st_reg, st_next; // Status bits 24:16: sticky flags plus latch and presence levels
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_reg, pslverr_next;
    logic irq_reg, irq_next;
    logic cmd_pend_reg, cmd_pend_next;
    hpsc_msg_type att_msg_reg, att_msg_next, pwr_msg_reg, pwr_msg_next;
    logic wr_fire, pres_now, pres_prev;
    logic [31:0] wmask, rd_word;
    logic [8:0] set_ev, clr_ev;

    // Two-stage synchroniser, then an edge-reference stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= HPSC_PINS_IDLE; // Idle levels avoid a false change flag after reset
            sync2_reg <= HPSC_PINS_IDLE;
            prev_reg <= HPSC_PINS_IDLE;
        end else begin
            sync1_reg <= slot_pins;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // Byte-lane mask and the write that takes effect
    always_comb begin
        wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
        wr_fire = psel && penable && pwrite && (state_reg == HPSC_APB_ANSWER) && slot_hit(paddr);
        pres_now = sync2_reg.presence || !sync2_reg.slot_impl;
        pres_prev = prev_reg.presence || !prev_reg.slot_impl;
    end

    // Event detection and software clears, indexed from bit 16
    always_comb begin
        set_ev = '0;
        clr_ev = '0;
        set_ev[HPSC_ST_BTN-16] = sync2_reg.button && !prev_reg.button;
        set_ev[HPSC_ST_PF-16] = sync2_reg.power_fault && !prev_reg.power_fault;
        set_ev[HPSC_ST_LATCH_CHG-16] = sync2_reg.retention_latch != prev_reg.retention_latch;
        set_ev[HPSC_ST_PRES_CHG-16] = pres_now != pres_prev;
        set_ev[HPSC_ST_CMD-16] = cmd_pend_reg;
        set_ev[HPSC_ST_DLL_CHG-16] = sync2_reg.link_active != prev_reg.link_active;
        if (wr_fire) begin
            clr_ev = pwdata[24:16] & wmask[24:16];
        end
        clr_ev[HPSC_ST_LATCH_CHG-16] = 1'b0;
        clr_ev[HPSC_ST_LATCH-16] = 1'b0;
        clr_ev[HPSC_ST_PRES-16] = 1'b0;
        clr_ev[23-16] = 1'b0;
    end

    // Control and status next values; set wins over clear
    always_comb begin
        ctl_next = ctl_reg;
        cmd_pend_next = 1'b0;
        att_msg_next = '0;
        pwr_msg_next = '0;
        if (wr_fire) begin
            ctl_next = (ctl_reg & ~(wmask[15:0] & HPSC_CTL_WMASK)) |
                (pwdata[15:0] & wmask[15:0] & HPSC_CTL_WMASK);
            cmd_pend_next = |pstrb[1:0]; // Controller finishes the command next cycle
            att_msg_next.valid = pstrb[0];
            att_msg_next.code = pwdata[HPSC_CTL_ATT_LO +: 2];
            pwr_msg_next.valid = pstrb[1];
            pwr_msg_next.code = pwdata[HPSC_CTL_PWRIND_LO +: 2];
        end
        st_next = (st_reg & ~clr_ev) | set_ev;
        st_next[HPSC_ST_LATCH-16] = sync2_reg.retention_latch;
        st_next[HPSC_ST_PRES-16] = pres_now;
        st_next[23-16] = 1'b0;
    end

    // Interrupt: any enabled flag, gated by the master enable
    always_comb begin
        irq_next = ctl_next[HPSC_CTL_HP_EN] && (
            (st_next[HPSC_ST_BTN-16] && ctl_next[HPSC_CTL_BTN_EN]) ||
            (st_next[HPSC_ST_PF-16] && ctl_next[HPSC_CTL_PF_EN]) ||
            (st_next[HPSC_ST_LATCH_CHG-16] && ctl_next[HPSC_CTL_LATCH_EN]) ||
            (st_next[HPSC_ST_PRES_CHG-16] && ctl_next[HPSC_CTL_PRES_EN]) ||
            (st_next[HPSC_ST_CMD-16] && ctl_next[HPSC_CTL_CMD_EN]) ||
            (st_next[HPSC_ST_DLL_CHG-16] && ctl_next[HPSC_CTL_DLL_EN]));
    end

    // Bus answer: one wait state, read data prepared in the first access cycle
    always_comb begin
        rd_word = {7'h00, st_reg, ctl_reg & HPSC_CTL_WMASK};
        state_next = HPSC_APB_WAIT;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        if (psel && penable && state_reg == HPSC_APB_WAIT) begin
            state_next = HPSC_APB_ANSWER;
            prdata_next = (!pwrite && slot_hit(paddr)) ? rd_word : HPSC_ZERO32;
            pslverr_next = !slot_hit(paddr);
        end
    end

    // Register all state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= HPSC_APB_WAIT;
            ctl_reg <= HPSC_CTL_RESET;
            st_reg <= '0;
            prdata_reg <= HPSC_ZERO32;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
            cmd_pend_reg <= 1'b0;
            att_msg_reg <= '0;
            pwr_msg_reg <= '0;
        end else begin
            state_reg <= state_next;
            ctl_reg <= ctl_next;
            st_reg <= st_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
            cmd_pend_reg <= cmd_pend_next;
            att_msg_reg <= att_msg_next;
            pwr_msg_reg <= pwr_msg_next;
        end
    end

    // Outputs straight from flops
    assign prdata = prdata_reg;
    assign pready = (state_reg == HPSC_APB_ANSWER);
    assign pslverr = pslverr_reg;
    assign hp_irq = irq_reg;
    assign att_ind = ctl_reg[HPSC_CTL_ATT_LO +: 2];
    assign pwr_ind = ctl_reg[HPSC_CTL_PWRIND_LO +: 2];
    assign slot_power_off = ctl_reg[HPSC_CTL_PWR_OFF];
    assign att_msg = att_msg_reg;
    assign pwr_msg = pwr_msg_reg;

endmodule

// ===== bench/hpsc_slot_model.sv
`timescale 1ns/1ps
module hpsc_slot_model
    import hpsc_pkg::*;
(
    input wire logic pclk, // Clock
    input wire hpsc_pins_type want, // Commanded slot state
    output hpsc_pins_type pins // Sense lines
);
    // Sensors settle one edge after the slot changes
    initial pins = '0;
    always @(posedge pclk) begin
        pins <= want;
    end
endmodule

// ===== bench/hpsc_slot_ctrl_chk.sv
`timescale 1ns/1ps
module hpsc_chk
    import hpsc_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic penable, // Access
    input wire logic pwrite, // Write
    input wire logic [HPSC_ADDR_W-1:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [3:0] pstrb, // Lanes
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic hp_irq, // Interrupt
    input wire logic [1:0] att_ind, // Attention
    input wire logic [1:0] pwr_ind, // Power
    input wire hpsc_msg_type att_msg, // Attention message
    input wire hpsc_msg_type pwr_msg // Power message
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic hit;
    // Answer at the slot word
    assign hit = pready && paddr == HPSC_SLOT_ADDR;
    ack_wait_a: assert property ($rose(penable) |-> !pready ##1 pready)
        else $error("answer timing wrong");
    unmapped_err_a: assert property (pready && paddr != HPSC_SLOT_ADDR |-> pslverr && prdata == HPSC_ZERO32)
        else $error("unmapped access not refused");
    rsvd_zero_a: assert property (hit && !pwrite |-> !pslverr && prdata[15:13] == 3'h0 && !prdata[23] && prdata[31:25] == 7'h00)
        else $error("reserved bits not zero");
    att_msg_a: assert property (hit && pwrite && pstrb[0] |=> att_msg.valid && att_msg.code == $past(pwdata[7:6]) && att_ind == att_msg.code)
        else $error("attention message wrong");
    pwr_msg_a: assert property (hit && pwrite && pstrb[1] |=> pwr_msg.valid && pwr_msg.code == $past(pwdata[9:8]) && pwr_ind == pwr_msg.code)
        else $error("power message wrong");
    msg_cause_a: assert property (att_msg.valid || pwr_msg.valid |-> $past(hit) && $past(pwrite))
        else $error("message without write");
    irq_master_a: assert property (hit && !pwrite && !prdata[5] |-> !hp_irq)
        else $error("interrupt with master off");
    irq_button_a: assert property (hit && !pwrite && prdata[5] && prdata[0] && prdata[16] |=> hp_irq)
        else $error("button interrupt missing");
    reset_vals_a: assert property ($rose(presetn) |-> att_ind == HPSC_IND_OFF && pwr_ind == HPSC_IND_ON && !hp_irq)
        else $error("reset values wrong");
endmodule
bind hpsc_slot_ctrl hpsc_chk u_chk(.pclk(pclk), .presetn(presetn), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hp_irq(hp_irq),
    .att_ind(att_ind), .pwr_ind(pwr_ind), .att_msg(att_msg), .pwr_msg(pwr_msg));

// ===== bench/test_hot_plug_slot_control_status.sv
`timescale 1ns/1ps
module test_hot_plug_slot_control_status;
    import hpsc_pkg::*;
    logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, e, hp_irq, slot_power_off, pready, pslverr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic [3:0] pstrb = '0;
    logic [1:0] att_ind, pwr_ind;
    hpsc_msg_type att_msg, pwr_msg;
    hpsc_pins_type pins, want = 6'h01;
    int error_cnt = 0, compares = 0, cyc = 0;
    always #50 pclk = ~pclk;
    hpsc_slot_ctrl dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .slot_pins(pins),
        .hp_irq(hp_irq), .att_ind(att_ind), .pwr_ind(pwr_ind), .slot_power_off(slot_power_off), .att_msg(att_msg),
        .pwr_msg(pwr_msg));
    hpsc_slot_model slot(.pclk(pclk), .want(want), .pins(pins));
    task chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // One transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task wt(input int n); repeat (n) @(posedge pclk); endtask
    task wr(input logic [31:0] d, input logic [3:0] s); apb(1'b1, HPSC_SLOT_ADDR, d, s); endtask
    task rd(input logic [31:0] x);
        apb(1'b0, HPSC_SLOT_ADDR, 32'h0, 4'h0);
        chk(r, x);
    endtask
    // Every control bit set; reserved bits and completion flag
    task t_ctl;
        wr(32'h0000FFFF, 4'h3);
        wt(2);
        chk({27'h0, slot_power_off, att_ind, pwr_ind}, 32'h1F);
        wt(1);
        chk({31'h0, hp_irq}, 32'h1);
        rd(32'h00101FFF);
        wr(32'h00100000, 4'hC);
        wt(3);
        chk({31'h0, hp_irq}, 32'h0);
        rd(32'h00001FFF);
    endtask
    // All indicator codes
    task t_ind;
        for (int c = 0; c < 4; c++) begin
            wr({22'h0, c[1:0], c[1:0], 6'h0}, 4'h3);
            wt(2);
            chk({28'h0, att_ind, pwr_ind}, {28'h0, c[1:0], c[1:0]});
        end
    endtask
    // Slot events, clearing, latch flag stays, master off
    task t_events;
        wr(32'h0000117F, 4'h3);
        want <= 6'h3F;
        wt(8);
        rd(32'h017F117F);
        wr(32'h01FF0000, 4'hC);
        wt(3);
        chk({31'h0, hp_irq}, 32'h1);
        rd(32'h0064117F);
        wr(32'h0000115F, 4'h3);
        wt(3);
        chk({31'h0, hp_irq}, 32'h0);
        rd(32'h0074115F);
    endtask
    // Unmapped word refused; slotless port reports a card
    task t_odd;
        apb(1'b1, 12'h0DC, 32'hFFFFFFFF, 4'hF);
        chk({31'h0, e}, 32'h1);
        rd(32'h0074115F);
        want <= 6'h00;
        wt(8);
        apb(1'b0, 12'h0DC, 32'h0, 4'h0);
        chk({e, r[30:0]}, 32'h80000000);
        rd(32'h0154115F);
    endtask
    task summarize;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        wt(4);
        presetn <= 1'b1;
        rd(32'h000001C0);
        t_ctl();
        t_ind();
        t_events();
        t_odd();
        summarize();
    end
endmodule
